// [design/week_alarm_subsecond_subweek_ctrl.sv]
// Week alarm register block with sub-second rate select and sub-week control.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module week_alarm_subsecond_subweek_ctrl (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Pins and events.
	input wire logic system_power_present_pin_i,
	output logic power_up_event_o,
	output logic irq_o
);
	logic pin_meta_q;
	logic pin_q;
	logic long_timer_run_q;
	logic wake_output_enable_q;
	logic [wk_pkg::WEEK_W-1:0] week_count_q;
	logic [wk_pkg::WEEK_W-1:0] week_compare_q;
	logic [wk_pkg::RATE_W-1:0] subsecond_rate_select_q;
	logic [wk_pkg::TICK_W-1:0] short_counter_clock_select_q;
	logic no_reload_q;
	logic power_present_gating_enable_q;
	logic alarm_wake_flag_q;
	logic [wk_pkg::SW_W-1:0] short_counter_reload_value_q;
	logic [wk_pkg::SW_W-1:0] short_count_q;
	logic [wk_pkg::IRQ_W-1:0] irq_status_q;
	logic [wk_pkg::IRQ_W-1:0] irq_mask_q;
	logic base_tick;
	logic second_tick;
	logic subsec_tick;
	logic [wk_pkg::DIV_W-1:0] div_val;
	logic take;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] wdata;
	logic week_hit;
	logic short_tick;
	logic short_expire;
	logic load_write;
	logic wake_d;

	// Picks the decrement source of the sub-week counter.
	function automatic logic pick_tick(input logic [wk_pkg::TICK_W-1:0] sel,
		input logic sec, input logic sub, input logic base);
		logic t;
		t = 1'b0;
		case (sel)
			wk_pkg::TSEL_SECOND: t = sec;
			wk_pkg::TSEL_SUBSEC: t = sub;
			wk_pkg::TSEL_BASE: t = base;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// Merges written bytes into a register's current value.
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [31:0] m);
		return (old_v & ~m) | (new_v & m);
	endfunction

	base_tick_gen u_base (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(base_tick)
	);

	time_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.base_tick_i(base_tick),
		.run_i(long_timer_run_q),
		.rate_i(subsecond_rate_select_q),
		.div_o(div_val),
		.second_o(second_tick),
		.subsec_o(subsec_tick)
	);

	assign take = cyc_i && stb_i && !ack_o;
	assign wr = take && we_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wdata = dat_i & wmask;
	assign week_hit = week_count_q >= week_compare_q;
	assign short_tick = pick_tick(short_counter_clock_select_q, second_tick,
		subsec_tick, base_tick);
	assign load_write = wr && (adr_i == wk_pkg::OFF_SUBWEEK_COUNT) && (sel_i[1:0] != 2'b00);
	assign short_expire = short_tick && (short_count_q == 9'h001) && !load_write;
	assign wake_d = wake_output_enable_q && week_hit
		&& (!power_present_gating_enable_q || pin_q);

	// Two-stage synchroniser for the power present pin.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			pin_meta_q <= system_power_present_pin_i;
			pin_q <= pin_meta_q;
		end
	end

	// Control register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			long_timer_run_q <= wk_pkg::RST_RUN;
			wake_output_enable_q <= wk_pkg::RST_WAKE_EN;
		end else if (wr && adr_i == wk_pkg::OFF_CONTROL && sel_i[0]) begin
			long_timer_run_q <= dat_i[wk_pkg::BIT_RUN];
			wake_output_enable_q <= dat_i[wk_pkg::BIT_WAKE_EN];
		end
	end

	// Week counter and compare.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			week_count_q <= wk_pkg::RST_WEEK_COUNT;
			week_compare_q <= wk_pkg::RST_WEEK_COMPARE;
		end else begin
			if (wr && adr_i == wk_pkg::OFF_WEEK_COUNT) begin
				week_count_q <= wk_pkg::WEEK_W'(merge(32'(week_count_q), dat_i, wmask));
			end else if (long_timer_run_q && second_tick) begin
				week_count_q <= week_count_q + 28'h0000001;
			end
			if (wr && adr_i == wk_pkg::OFF_WEEK_COMPARE) begin
				week_compare_q <= wk_pkg::WEEK_W'(merge(32'(week_compare_q), dat_i, wmask));
			end
		end
	end

	// Sub-second rate select.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			subsecond_rate_select_q <= wk_pkg::RST_RATE;
		end else if (wr && adr_i == wk_pkg::OFF_RATE_SELECT && sel_i[0]) begin
			subsecond_rate_select_q <= dat_i[wk_pkg::RATE_W-1:0];
		end
	end

	// Sub-week control fields; bit 0 and the pin level bit hold no state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			short_counter_clock_select_q <= wk_pkg::RST_TICK_SEL;
			no_reload_q <= 1'b0;
			power_present_gating_enable_q <= 1'b0;
		end else if (wr && adr_i == wk_pkg::OFF_SUBWEEK_CTRL) begin
			if (sel_i[0]) begin
				no_reload_q <= dat_i[wk_pkg::BIT_NO_RELOAD];
				power_present_gating_enable_q <= dat_i[wk_pkg::BIT_GATE_EN];
			end
			if (sel_i[0] && sel_i[1]) begin
				short_counter_clock_select_q <= dat_i[wk_pkg::TICK_LSB+:wk_pkg::TICK_W];
			end
		end
	end

	// Wake flag: hardware set wins over a one written to clear it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_wake_flag_q <= 1'b0;
		end else if (wake_output_enable_q && week_hit) begin
			alarm_wake_flag_q <= 1'b1;
		end else if (wr && adr_i == wk_pkg::OFF_SUBWEEK_CTRL
			&& wdata[wk_pkg::BIT_WAKE_FLAG]) begin
			alarm_wake_flag_q <= 1'b0;
		end
	end

	// Sub-week load value and down counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			short_counter_reload_value_q <= wk_pkg::RST_SW_LOAD;
			short_count_q <= '0;
		end else if (load_write) begin
			short_counter_reload_value_q <= dat_i[wk_pkg::SW_W-1:0];
			short_count_q <= dat_i[wk_pkg::SW_W-1:0];
		end else if (short_expire) begin
			if (no_reload_q) begin
				short_count_q <= '0;
			end else begin
				short_count_q <= short_counter_reload_value_q;
			end
		end else if (short_tick && short_count_q != 9'h000) begin
			short_count_q <= short_count_q - 9'h001;
		end
	end

	// Sticky interrupt status, write one to clear, with its mask.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_q <= wk_pkg::RST_IRQ;
			irq_mask_q <= wk_pkg::RST_IRQ;
		end else begin
			for (int i = 0; i < wk_pkg::IRQ_W; i++) begin
				if (wr && adr_i == wk_pkg::OFF_IRQ_STATUS && wdata[i]) begin
					irq_status_q[i] <= 1'b0;
				end
			end
			if (week_hit) begin
				irq_status_q[wk_pkg::IRQ_WEEK] <= 1'b1;
			end
			if (short_expire) begin
				irq_status_q[wk_pkg::IRQ_SUBWEEK] <= 1'b1;
			end
			if (subsec_tick) begin
				irq_status_q[wk_pkg::IRQ_SUBSEC] <= 1'b1;
			end
			if (wr && adr_i == wk_pkg::OFF_IRQ_MASK && sel_i[0]) begin
				irq_mask_q <= dat_i[wk_pkg::IRQ_W-1:0];
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_up_event_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			power_up_event_o <= wake_d;
			irq_o <= |(irq_status_q & irq_mask_q);
		end
	end

	// Bus answer: one cycle after the request, unmapped reads return zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= take;
			dat_o <= '0;
			if (take && !we_i) begin
				if (adr_i == wk_pkg::OFF_CONTROL) begin
					dat_o[wk_pkg::BIT_RUN] <= long_timer_run_q;
					dat_o[wk_pkg::BIT_WAKE_EN] <= wake_output_enable_q;
				end else if (adr_i == wk_pkg::OFF_WEEK_COUNT) begin
					dat_o <= 32'(week_count_q);
				end else if (adr_i == wk_pkg::OFF_WEEK_COMPARE) begin
					dat_o <= 32'(week_compare_q);
				end else if (adr_i == wk_pkg::OFF_DIVIDER) begin
					dat_o <= 32'(div_val);
				end else if (adr_i == wk_pkg::OFF_RATE_SELECT) begin
					dat_o <= 32'(subsecond_rate_select_q);
				end else if (adr_i == wk_pkg::OFF_SUBWEEK_CTRL) begin
					dat_o[wk_pkg::TICK_LSB+:wk_pkg::TICK_W] <= short_counter_clock_select_q;
					dat_o[wk_pkg::BIT_NO_RELOAD] <= no_reload_q;
					dat_o[wk_pkg::BIT_GATE_EN] <= power_present_gating_enable_q;
					dat_o[wk_pkg::BIT_PIN_LEVEL] <= pin_q;
					dat_o[wk_pkg::BIT_WAKE_FLAG] <= alarm_wake_flag_q;
				end else if (adr_i == wk_pkg::OFF_SUBWEEK_COUNT) begin
					dat_o[wk_pkg::SW_W-1:0] <= short_counter_reload_value_q;
					dat_o[wk_pkg::SW_STATUS_LSB+:wk_pkg::SW_W] <= short_count_q;
				end else if (adr_i == wk_pkg::OFF_IRQ_STATUS) begin
					dat_o[wk_pkg::IRQ_W-1:0] <= irq_status_q;
				end else if (adr_i == wk_pkg::OFF_IRQ_MASK) begin
					dat_o[wk_pkg::IRQ_W-1:0] <= irq_mask_q;
				end
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_rate_zero_quiet: assert property (
		subsecond_rate_select_q == 4'h0 |=> !subsec_tick)
		else $error("sub-second event with rate zero");
	a_rate_top_each: assert property (
		long_timer_run_q && subsecond_rate_select_q == 4'hf && base_tick
		&& !(wr && adr_i == wk_pkg::OFF_RATE_SELECT) |=> subsec_tick)
		else $error("top rate missed a base tick");
	a_expire_reload: assert property (
		short_expire && !no_reload_q |=> short_count_q == $past(short_counter_reload_value_q))
		else $error("sub-week counter not reloaded");
	a_expire_hold: assert property (
		short_expire && no_reload_q |=> short_count_q == 9'h000
		##1 ($past(load_write) || short_count_q == 9'h000))
		else $error("sub-week counter reloaded when told not to");
	a_load_write: assert property (
		load_write |=> short_count_q == $past(dat_i[8:0]))
		else $error("load write did not reach the counter");
	a_gate_low: assert property (
		power_present_gating_enable_q && !pin_q |=> !power_up_event_o)
		else $error("wake output while power pin low");
	a_gate_ignored: assert property (
		wake_output_enable_q && week_hit && !power_present_gating_enable_q
		|=> power_up_event_o)
		else $error("wake output missing with gating off");
	a_wake_disabled: assert property (
		!wake_output_enable_q |=> !power_up_event_o)
		else $error("wake output while disabled");
	a_wake_drop: assert property (
		power_up_event_o && !week_hit && alarm_wake_flag_q |=> !power_up_event_o)
		else $error("wake output held by the flag");
	a_flag_set: assert property (
		wake_output_enable_q && week_hit |=> alarm_wake_flag_q)
		else $error("wake flag not set");
	a_flag_clear: assert property (
		wr && adr_i == wk_pkg::OFF_SUBWEEK_CTRL && wdata[1]
		&& !(wake_output_enable_q && week_hit) |=> !alarm_wake_flag_q)
		else $error("wake flag not cleared by a one");
	a_week_step: assert property (
		long_timer_run_q && second_tick && !(wr && adr_i == wk_pkg::OFF_WEEK_COUNT)
		|=> week_count_q == $past(week_count_q) + 28'h0000001)
		else $error("week counter missed a second");
	a_div_held: assert property (
		!long_timer_run_q |=> div_val == 15'h0000)
		else $error("divider moved while stopped");
	a_ctrl_read: assert property (
		take && !we_i && adr_i == wk_pkg::OFF_SUBWEEK_CTRL
		|=> ack_o && !dat_o[0] && dat_o[4] == $past(pin_q))
		else $error("sub-week control read wrong");

	c_subsec_event: cover property (subsecond_rate_select_q == 4'hf && subsec_tick);
	c_subweek_reload: cover property (short_expire && !no_reload_q);
	c_wake_rise: cover property (!power_up_event_o ##1 power_up_event_o);
endmodule // week_alarm_subsecond_subweek_ctrl
`default_nettype wire

// [common/wk_pkg.sv]
// Constants shared by the week alarm sub-second and sub-week control logic.
package wk_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned BASE_HZ = 32_768;
	localparam int ACC_W = 25;
	localparam logic [ACC_W-1:0] CLK_HZ_C = ACC_W'(CLK_HZ);
	localparam logic [ACC_W-1:0] BASE_HZ_C = ACC_W'(BASE_HZ);
	localparam int DIV_W = 15;
	localparam int WEEK_W = 28;
	localparam int SW_W = 9;
	localparam int RATE_W = 4;
	localparam int TICK_W = 3;
	localparam int IRQ_W = 3;

	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_WEEK_COUNT = 8'h04;
	localparam logic [7:0] OFF_WEEK_COMPARE = 8'h08;
	localparam logic [7:0] OFF_DIVIDER = 8'h0c;
	localparam logic [7:0] OFF_RATE_SELECT = 8'h10;
	localparam logic [7:0] OFF_SUBWEEK_CTRL = 8'h14;
	localparam logic [7:0] OFF_SUBWEEK_COUNT = 8'h18;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;

	localparam int BIT_RUN = 0;
	localparam int BIT_WAKE_EN = 6;
	localparam int BIT_WAKE_FLAG = 1;
	localparam int BIT_PIN_LEVEL = 4;
	localparam int BIT_GATE_EN = 5;
	localparam int BIT_NO_RELOAD = 6;
	localparam int TICK_LSB = 7;
	localparam int SW_STATUS_LSB = 16;
	localparam int IRQ_WEEK = 0;
	localparam int IRQ_SUBWEEK = 1;
	localparam int IRQ_SUBSEC = 2;

	localparam logic RST_RUN = 1'b1;
	localparam logic RST_WAKE_EN = 1'b0;
	localparam logic [WEEK_W-1:0] RST_WEEK_COUNT = 28'h0000000;
	localparam logic [WEEK_W-1:0] RST_WEEK_COMPARE = 28'h0ffffff;
	localparam logic [RATE_W-1:0] RST_RATE = 4'h0;
	localparam logic [TICK_W-1:0] RST_TICK_SEL = 3'h0;
	localparam logic [SW_W-1:0] RST_SW_LOAD = 9'h000;
	localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

	localparam logic [TICK_W-1:0] TSEL_SECOND = 3'h1;
	localparam logic [TICK_W-1:0] TSEL_SUBSEC = 3'h2;
	localparam logic [TICK_W-1:0] TSEL_BASE = 3'h3;
endpackage

// [design/base_tick_gen.sv]
// Fractional divider that makes a 32.768 kHz enable pulse from the system clock.
`timescale 1ns/1ps
`default_nettype none
module base_tick_gen (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Time base enable.
	output logic tick_o
);
	logic [wk_pkg::ACC_W-1:0] acc_q;
	logic [wk_pkg::ACC_W:0] sum;

	assign sum = {1'b0, acc_q} + {1'b0, wk_pkg::BASE_HZ_C};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q <= '0;
			tick_o <= 1'b0;
		end else if (sum >= {1'b0, wk_pkg::CLK_HZ_C}) begin
			acc_q <= wk_pkg::ACC_W'(sum - {1'b0, wk_pkg::CLK_HZ_C});
			tick_o <= 1'b1;
		end else begin
			acc_q <= sum[wk_pkg::ACC_W-1:0];
			tick_o <= 1'b0;
		end
	end
endmodule // base_tick_gen
`default_nettype wire

// [design/time_divider.sv]
// Fifteen-bit divider giving the one-second tick and the selected sub-second tick.
`timescale 1ns/1ps
`default_nettype none
module time_divider (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic base_tick_i,
	input wire logic run_i,
	input wire logic [wk_pkg::RATE_W-1:0] rate_i,
	// Divider state and ticks.
	output logic [wk_pkg::DIV_W-1:0] div_o,
	output logic second_o,
	output logic subsec_o
);
	logic [wk_pkg::DIV_W-1:0] div_d;
	logic [wk_pkg::DIV_W-1:0] tap_mask;

	assign div_d = div_o + 15'h0001;
	assign tap_mask = 15'h7fff >> rate_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			div_o <= '0;
			second_o <= 1'b0;
			subsec_o <= 1'b0;
		end else begin
			second_o <= base_tick_i && (div_d == 15'h0000);
			subsec_o <= base_tick_i && (rate_i != 4'h0) && ((div_d & tap_mask) == 15'h0000);
			if (base_tick_i) begin
				div_o <= div_d;
			end
		end
	end
endmodule // time_divider
`default_nettype wire

// [verif/test_week_alarm_subsecond_subweek_ctrl.sv]
// Self-checking testbench for the week alarm sub-second and sub-week control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_week_alarm_subsecond_subweek_ctrl;
	typedef struct {logic [31:0] exp; logic [31:0] mask; string name;} note_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic pin_i = 1'b0;
	logic [31:0] dat_o;
	logic ack_o;
	logic power_up_event_o;
	logic irq_o;
	int failures = 0;
	int n_tests = 0;
	integer seed = 11;
	logic [31:0] rv;
	note_t notes[$];
	note_t cur;

	always #25 clk_i = ~clk_i;

	week_alarm_subsecond_subweek_ctrl u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.system_power_present_pin_i(pin_i),
		.power_up_event_o(power_up_event_o),
		.irq_o(irq_o)
	);

	task automatic conclude;
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One classic Wishbone cycle; the expected read result is noted before the request.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [31:0] m, input logic [31:0] e, input string nm);
		notes.push_back('{exp: e, mask: m, name: nm});
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf, 32'h0, 32'h0, "write");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input string nm);
		bus(1'b0, a, 32'h0, 4'hf, m, e, nm);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Checks the wake output or the interrupt line once the pin and register lags settle.
	task automatic lvl(input bit wake, input logic e);
		repeat (5) @(posedge clk_i);
		#1;
		if (wake) begin
			`CHK("wake output", e, power_up_event_o)
		end else begin
			`CHK("irq output", e, irq_o)
		end
	endtask

	// Takes the oldest note off the queue at every acknowledge.
	always @(posedge clk_i) begin
		if (ack_o === 1'b1) begin
			if (notes.size() == 0) begin
				`CHK("unexpected ack", 1'b0, 1'b1)
			end else begin
				cur = notes.pop_front();
				if (cur.mask != 32'h0) begin
					`CHK(cur.name, cur.exp, dat_o & cur.mask)
				end
			end
		end
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		failures++;
		conclude();
	end

	initial begin
		idle(10);
		rst_i <= 1'b0;
		rd(8'h00, 32'hffffffff, 32'h00000001, "control");
		rd(8'h08, 32'hffffffff, 32'h00ffffff, "compare");
		rd(8'h10, 32'hffffffff, 32'h00000000, "rate select");
		rd(8'h14, 32'hffffffff, 32'h00000000, "subweek control");
		rd(8'h30, 32'hffffffff, 32'h00000000, "unmapped");
		for (int i = 0; i < 4; i++) begin
			rv = $random(seed);
			wr(8'h10, rv);
			rd(8'h10, 32'hffffffff, {28'h0, rv[3:0]}, "rate select");
		end
		wr(8'h30, 32'hffffffff);
		rd(8'h30, 32'hffffffff, 32'h00000000, "unmapped");
		wr(8'h14, 32'hffffffdf);
		rd(8'h14, 32'hffffffff, 32'h000003c0, "subweek control");
		wr(8'h14, 32'h00000021);
		rd(8'h14, 32'hffffffff, 32'h00000020, "subweek control");
		pin_i <= 1'b1;
		idle(4);
		rd(8'h14, 32'hffffffff, 32'h00000030, "pin level");
		wr(8'h00, 32'h00000041);
		wr(8'h08, 32'h00000000);
		lvl(1'b1, 1'b1);
		rd(8'h14, 32'hffffffff, 32'h00000032, "wake flag");
		pin_i <= 1'b0;
		lvl(1'b1, 1'b0);
		wr(8'h14, 32'h00000000);
		lvl(1'b1, 1'b1);
		wr(8'h08, 32'h00ffffff);
		lvl(1'b1, 1'b0);
		rd(8'h14, 32'h00000002, 32'h00000002, "wake flag");
		wr(8'h14, 32'h00000000);
		rd(8'h14, 32'h00000002, 32'h00000002, "wake flag");
		wr(8'h14, 32'h00000002);
		rd(8'h14, 32'h00000002, 32'h00000000, "wake flag");
		wr(8'h08, 32'h00000000);
		lvl(1'b1, 1'b1);
		wr(8'h00, 32'h00000001);
		lvl(1'b1, 1'b0);
		wr(8'h14, 32'h00000002);
		rd(8'h14, 32'h00000002, 32'h00000000, "wake flag");
		rv = $random(seed);
		wr(8'h04, rv);
		rd(8'h04, 32'hffffffff, {4'h0, rv[27:0]}, "week count");
		lvl(1'b0, 1'b0);
		wr(8'h2c, 32'h00000001);
		lvl(1'b0, 1'b1);
		wr(8'h2c, 32'h00000000);
		lvl(1'b0, 1'b0);
		wr(8'h08, 32'h00ffffff);
		wr(8'h10, 32'h00000000);
		wr(8'h28, 32'h00000007);
		idle(2000);
		rd(8'h28, 32'h00000004, 32'h00000000, "subsecond status");
		wr(8'h10, 32'h0000000f);
		idle(1300);
		rd(8'h28, 32'h00000004, 32'h00000004, "subsecond status");
		wr(8'h2c, 32'h00000004);
		lvl(1'b0, 1'b1);
		wr(8'h2c, 32'h00000000);
		wr(8'h10, 32'h00000000);
		wr(8'h14, 32'h00000180);
		wr(8'h18, 32'h00000001);
		wr(8'h28, 32'h00000007);
		idle(2000);
		rd(8'h18, 32'h01ff0000, 32'h00010000, "subweek count");
		rd(8'h28, 32'h00000002, 32'h00000002, "subweek status");
		wr(8'h14, 32'h000001c0);
		wr(8'h18, 32'h00000003);
		idle(3000);
		rd(8'h18, 32'h01ff0000, 32'h00000000, "subweek count");
		wr(8'h10, 32'h0000000f);
		wr(8'h14, 32'h00000140);
		wr(8'h18, 32'h00000002);
		wr(8'h28, 32'h00000007);
		idle(2000);
		rd(8'h18, 32'h01ff0000, 32'h00000000, "subweek count");
		rd(8'h28, 32'h00000002, 32'h00000002, "subweek status");
		wr(8'h14, 32'h00000000);
		bus(1'b1, 8'h14, 32'h000001c0, 4'h1, 32'h0, 32'h0, "write");
		rd(8'h14, 32'hffffffff, 32'h00000040, "subweek control");
		wr(8'h18, 32'h00000005);
		rd(8'h18, 32'h01ff0000, 32'h00050000, "subweek count");
		idle(1500);
		rd(8'h18, 32'h01ff0000, 32'h00050000, "subweek count");
		wr(8'h18, 32'h00000000);
		rd(8'h18, 32'h01ff0000, 32'h00000000, "subweek count");
		wr(8'h00, 32'h00000000);
		idle(3);
		rd(8'h0c, 32'hffffffff, 32'h00000000, "divider");
		idle(3);
		conclude();
	end
endmodule // test_week_alarm_subsecond_subweek_ctrl
`default_nettype wire
